// ### verilog/anx_regs.sv
`timescale 1ns/100ps
`include "anx_defs.svh"

// Function
// - expansion reserved bits 15..5 always read zero.
// - override-protected bits change only while the override input is one.
// - parallel detection fault bit sets on fault and latches high.
// - partner next-page bit follows partner's received next page flag.
// - local next-page capable bit always reads one.
// - page received bit sets on each stored partner word, latches high.
// - reading the expansion register clears page received.
// - partner auto-negotiation bit sets once valid pulse bursts arrive.
// - expansion status register sits at management address 6.
// - next page register at address 7, toggle and bit 14 read-only.
// - next page register bit 14 always reads zero.
// - outgoing more-pages flag follows register bit 15.
// - next pages sent only when flag set and partner supports them.
// - outgoing message page flag follows register bit 13.
// - outgoing can-comply flag follows register bit 12.
// - toggle inverts with each next page word sent without a base word in the same cycle.
// - first next page toggle is inverse of base word bit 11.
// - bits 10..0 go out as message or unformatted code.
module anx_regs (
    input  wire logic                    clk,
    input  wire logic                    rstn,
    input  wire logic                    mdc,
    input  wire logic                    mdio_in,
    output logic                         mdio_out,
    output logic                         mdio_oe_n,
    input  wire logic [4:0]              phy_addr,
    input  wire logic                    cmd_override,
    input  wire anx_pkg::anx_an_status_t an_status,
    input  wire logic                    base_word_bit11,
    input  wire logic                    base_word_sent,
    input  wire logic                    np_word_sent,
    output anx_pkg::anx_np_word_t        np_word,
    output logic                         np_enable,
    output logic [10:0]                  reserved_aux
);

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [2:0] mdc_sync_r;
    logic [1:0] mdio_sync_r;
    logic [4:0] pa_meta_r;
    logic [4:0] pa_sync_r;
    logic       mdc_rise;
    logic       mdio_bit;

    // third mdc stage only feeds the edge detector, never the first
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mdc_sync_r  <= 3'h0;
            mdio_sync_r <= 2'h0;
            pa_meta_r   <= 5'h00;
            pa_sync_r   <= 5'h00;
        end else begin
            mdc_sync_r  <= {mdc_sync_r[1:0], mdc};
            mdio_sync_r <= {mdio_sync_r[0], mdio_in};
            // strapped address pins, settled long before the first frame
            pa_meta_r   <= phy_addr;
            pa_sync_r   <= pa_meta_r;
        end
    end

    // data and clock share the same two-stage delay, so each bit lines up with its edge
    assign mdc_rise = mdc_sync_r[1] & ~mdc_sync_r[2];
    // limitation: mdc halves shorter than about two clocks lose bits
    assign mdio_bit = mdio_sync_r[1];

    // ----------------------------------------------------------------
    // frame sequencer
    // ----------------------------------------------------------------
    anx_pkg::anx_state_t state_r, state_nxt;
    logic [5:0]  ones_r, ones_nxt;
    logic [4:0]  cnt_r, cnt_nxt;
    logic [12:0] hdr_r, hdr_nxt;
    logic [15:0] shift_r, shift_nxt;
    logic        mdio_out_r, mdio_out_nxt;
    logic        mdio_oe_n_r, mdio_oe_n_nxt;
    logic        rd_exp;
    logic        wr_exp;
    logic        wr_nptx;
    logic [15:0] rdata;
    logic [12:0] hdr_full;

    // read mux: unmapped addresses answer zero
    function automatic logic [15:0] read_mux(input logic [4:0] ra,
                                             input logic [15:0] exp_v,
                                             input logic [15:0] nptx_v);
        logic [15:0] r;
        r = 16'h0000;
        if (ra == `ANX_REG_EXP) begin
            r = exp_v;
        end else if (ra == `ANX_REG_NPTX) begin
            r = nptx_v;
        end
        return r;
    endfunction : read_mux

    assign hdr_full = {hdr_r[11:0], mdio_bit};

    // one bit per synchronised mdc rising edge; slow mdc assumed
    always_comb begin
        state_nxt     = state_r;
        ones_nxt      = ones_r;
        cnt_nxt       = cnt_r;
        hdr_nxt       = hdr_r;
        shift_nxt     = shift_r;
        mdio_out_nxt  = mdio_out_r;
        mdio_oe_n_nxt = mdio_oe_n_r;
        rd_exp        = 1'b0;
        wr_exp        = 1'b0;
        wr_nptx       = 1'b0;
        if (mdc_rise) begin
            case (state_r)
                anx_pkg::ANX_PRE: begin
                    if (mdio_bit) begin
                        // extra preamble ones saturate the counter
                        if (ones_r != `ANX_PRE_ONES) begin
                            ones_nxt = ones_r + 6'h01;
                        end
                    end else if (ones_r == `ANX_PRE_ONES) begin
                        // first start bit seen after full preamble
                        state_nxt = anx_pkg::ANX_HDR;
                        cnt_nxt   = 5'h00;
                        ones_nxt  = 6'h00;
                    end else begin
                        ones_nxt = 6'h00;
                    end
                end
                anx_pkg::ANX_HDR: begin
                    hdr_nxt = hdr_full;
                    cnt_nxt = cnt_r + 5'h01;
                    if (cnt_r == `ANX_HDR_LAST) begin
                        cnt_nxt   = 5'h00;
                        state_nxt = anx_pkg::ANX_PRE;
                        if (hdr_full[12] && hdr_full[9:5] == pa_sync_r) begin
                            if (hdr_full[11:10] == `ANX_OP_RD) begin
                                state_nxt = anx_pkg::ANX_TA;
                                // whole word captured now; a later set waits for the next read
                                shift_nxt = rdata;
                                rd_exp    = (hdr_full[4:0] == `ANX_REG_EXP);
                            end else if (hdr_full[11:10] == `ANX_OP_WR) begin
                                state_nxt = anx_pkg::ANX_TA;
                            end
                        end
                    end
                end
                anx_pkg::ANX_TA: begin
                    if (hdr_r[11:10] == `ANX_OP_RD) begin
                        // drive the low half of turnaround
                        mdio_out_nxt  = 1'b0;
                        mdio_oe_n_nxt = 1'b0;
                        state_nxt     = anx_pkg::ANX_RD;
                        cnt_nxt       = 5'h00;
                    end else if (cnt_r == `ANX_TA_LAST) begin
                        state_nxt = anx_pkg::ANX_WR;
                        cnt_nxt   = 5'h00;
                    end else begin
                        cnt_nxt = cnt_r + 5'h01;
                    end
                end
                anx_pkg::ANX_RD: begin
                    if (cnt_r == `ANX_DATA_END) begin
                        // release the line one bit after the last data bit
                        mdio_oe_n_nxt = 1'b1;
                        mdio_out_nxt  = 1'b0;
                        state_nxt     = anx_pkg::ANX_PRE;
                    end else begin
                        mdio_out_nxt = shift_r[15];
                        shift_nxt    = {shift_r[14:0], 1'b0};
                        cnt_nxt      = cnt_r + 5'h01;
                    end
                end
                anx_pkg::ANX_WR: begin
                    shift_nxt = {shift_r[14:0], mdio_bit};
                    cnt_nxt   = cnt_r + 5'h01;
                    // a short frame never reaches the last bit and writes nothing
                    if (cnt_r == `ANX_DATA_LAST) begin
                        state_nxt = anx_pkg::ANX_PRE;
                        wr_exp    = (hdr_r[4:0] == `ANX_REG_EXP);
                        wr_nptx   = (hdr_r[4:0] == `ANX_REG_NPTX);
                    end
                end
                default: begin
                    state_nxt = anx_pkg::ANX_PRE;
                end
            endcase
        end
    end

    // sequencer state, registers only
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_r     <= anx_pkg::ANX_PRE;
            ones_r      <= 6'h00;
            cnt_r       <= 5'h00;
            hdr_r       <= 13'h0000;
            shift_r     <= 16'h0000;
            mdio_out_r  <= 1'b0;
            mdio_oe_n_r <= 1'b1;
        end else begin
            state_r     <= state_nxt;
            ones_r      <= ones_nxt;
            cnt_r       <= cnt_nxt;
            hdr_r       <= hdr_nxt;
            shift_r     <= shift_nxt;
            mdio_out_r  <= mdio_out_nxt;
            mdio_oe_n_r <= mdio_oe_n_nxt;
        end
    end

    // ----------------------------------------------------------------
    // register bank
    // ----------------------------------------------------------------
    logic        pd_fault_r, pd_fault_nxt;
    logic        pg_rx_r, pg_rx_nxt;
    logic        lp_np_r, lp_np_nxt;
    logic        lp_an_r, lp_an_nxt;
    logic [10:0] aux_r, aux_nxt;
    logic [15:0] nptx_r, nptx_nxt;
    logic        toggle_r, toggle_nxt;
    logic        np_en_r, np_en_nxt;
    logic [15:0] exp_v;
    logic [15:0] nptx_v;
    logic [15:0] wdata;

    // the last data bit is still in flight, so splice it in
    assign wdata = {shift_r[14:0], mdio_bit};

    // status image; reserved bits stay zero, decode above
    always_comb begin
        exp_v                  = 16'h0000;
        exp_v[`ANX_EXP_PD_FLT] = pd_fault_r;
        exp_v[`ANX_EXP_LP_NP]  = lp_np_r;
        exp_v[`ANX_EXP_LOC_NP] = 1'b1;
        exp_v[`ANX_EXP_PG_RX]  = pg_rx_r;
        exp_v[`ANX_EXP_LP_AN]  = lp_an_r;
    end

    // bit 14 read zero; toggle is hardware owned
    assign nptx_v = {nptx_r[15], 1'b0, nptx_r[13:12], toggle_r, nptx_r[10:0]};
    assign rdata  = read_mux(hdr_full[4:0], exp_v, nptx_v);

    // latched flags: a set in the read cycle wins over the clear
    always_comb begin
        // fault latch, returns to live value after a read
        pd_fault_nxt = an_status.pd_fault | (pd_fault_r & ~rd_exp);
        pg_rx_nxt    = an_status.page_stored | (pg_rx_r & ~rd_exp);
        // reserved bits only reach the auxiliary output, never the read data
        aux_nxt      = aux_r;
        if (wr_exp && cmd_override) begin
            aux_nxt = wdata[`ANX_EXP_RSV_HI:`ANX_EXP_RSV_LO];
        end
        nptx_nxt = nptx_r;
        if (wr_nptx) begin
            nptx_nxt = (wdata & `ANX_NPTX_WMASK) | (nptx_r & ~`ANX_NPTX_WMASK);
        end
        // base word and next page word in one cycle: the base word wins
        toggle_nxt = toggle_r;
        if (base_word_sent) begin
            toggle_nxt = ~base_word_bit11;
        end else if (np_word_sent) begin
            toggle_nxt = ~toggle_r;
        end
        lp_np_nxt = an_status.lp_np_capable;
        lp_an_nxt = an_status.flp_valid;
        // next page gating, both ends must support it
        np_en_nxt = nptx_nxt[15] & an_status.lp_np_capable;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pd_fault_r <= 1'b0;
            pg_rx_r    <= 1'b0;
            lp_np_r    <= 1'b0;
            lp_an_r    <= 1'b0;
            aux_r      <= `ANX_RSV_AUX_RST;
            nptx_r     <= `ANX_NPTX_RST;
            toggle_r   <= 1'b0;
            np_en_r    <= 1'b0;
        end else begin
            pd_fault_r <= pd_fault_nxt;
            pg_rx_r    <= pg_rx_nxt;
            lp_np_r    <= lp_np_nxt;
            lp_an_r    <= lp_an_nxt;
            aux_r      <= aux_nxt;
            nptx_r     <= nptx_nxt;
            toggle_r   <= toggle_nxt;
            np_en_r    <= np_en_nxt;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    anx_pkg::anx_np_word_t np_word_r, np_word_nxt;

    always_comb begin
        np_word_nxt.more_pages_flag   = nptx_nxt[15];
        np_word_nxt.rsvd              = 1'b0;
        np_word_nxt.message_page_flag = nptx_nxt[13];
        np_word_nxt.can_comply_flag   = nptx_nxt[12];
        np_word_nxt.toggle            = toggle_nxt;
        np_word_nxt.code              = nptx_nxt[10:0];
    end

    // built from next values so word and register agree in the same cycle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            np_word_r <= '0;
        end else begin
            np_word_r <= np_word_nxt;
        end
    end

    // every output is a plain flop copy
    assign mdio_out     = mdio_out_r;
    assign mdio_oe_n    = mdio_oe_n_r;
    assign np_word      = np_word_r;
    assign np_enable    = np_en_r;
    assign reserved_aux = aux_r;

endmodule : anx_regs

// ### verilog/anx_defs.svh
`ifndef ANX_DEFS_SVH
`define ANX_DEFS_SVH

// ----------------------------------------------------------------
// management register addresses
// ----------------------------------------------------------------
`define ANX_REG_EXP      5'h06
`define ANX_REG_NPTX     5'h07

// ----------------------------------------------------------------
// expansion status field positions
// ----------------------------------------------------------------
`define ANX_EXP_LP_AN    0
`define ANX_EXP_PG_RX    1
`define ANX_EXP_LOC_NP   2
`define ANX_EXP_LP_NP    3
`define ANX_EXP_PD_FLT   4
`define ANX_EXP_RSV_LO   5
`define ANX_EXP_RSV_HI   15

// ----------------------------------------------------------------
// next page transmit register layout and reset
// ----------------------------------------------------------------
`define ANX_NPTX_RST     16'h2001
`define ANX_NPTX_WMASK   16'hb7ff
`define ANX_RSV_AUX_RST  11'h000

// ----------------------------------------------------------------
// clause-22 frame constants
// ----------------------------------------------------------------
`define ANX_PRE_ONES     6'h20
`define ANX_OP_RD        2'h2
`define ANX_OP_WR        2'h1
`define ANX_HDR_LAST     5'h0c
`define ANX_DATA_LAST    5'h0f
`define ANX_DATA_END     5'h10
`define ANX_TA_LAST      5'h01

`endif

// ### verilog/anx_pkg.sv
package anx_pkg;

    // outgoing next page link control word
    typedef struct packed {
        logic        more_pages_flag;
        logic        rsvd;
        logic        message_page_flag;
        logic        can_comply_flag;
        logic        toggle;
        logic [10:0] code;
    } anx_np_word_t;

    // live status from the negotiation engine
    typedef struct packed {
        logic pd_fault;
        logic lp_np_capable;
        logic page_stored;
        logic flp_valid;
    } anx_an_status_t;

    // management frame sequencer
    typedef enum logic [2:0] {
        ANX_PRE,
        ANX_HDR,
        ANX_TA,
        ANX_RD,
        ANX_WR
    } anx_state_t;

endpackage : anx_pkg

// ### dv/anx_regs_props.sv
`timescale 1ns/100ps
module anx_regs_props (
    input wire logic                    clk,
    input wire logic                    rstn,
    input wire logic                    mdc,
    input wire logic                    mdio_out,
    input wire logic                    mdio_oe_n,
    input wire logic                    cmd_override,
    input wire anx_pkg::anx_an_status_t an_status,
    input wire logic                    base_word_bit11,
    input wire logic                    base_word_sent,
    input wire logic                    np_word_sent,
    input wire anx_pkg::anx_np_word_t   np_word,
    input wire logic                    np_enable,
    input wire logic [10:0]             reserved_aux
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // ------
    // checks
    // ------
    a_np_rsvd_zero: assert property (np_word.rsvd == 1'b0)
        else $error("np word reserved bit set");
    a_np_enable_gate: assert property (np_enable == (np_word.more_pages_flag && $past(an_status.lp_np_capable)))
        else $error("np enable wrong");
    a_toggle_first: assert property (base_word_sent ##1 (!base_word_sent && !np_word_sent)
        |-> ##1 np_word.toggle == !$past(base_word_bit11, 2)) else $error("first toggle wrong");
    // quiet cycles around the pulse keep the pipeline delay out of the picture
    a_toggle_flip: assert property ((!base_word_sent && !np_word_sent)[*2] ##1 (np_word_sent && !base_word_sent)
        ##1 (!base_word_sent && !np_word_sent)[*2] |-> np_word.toggle != $past(np_word.toggle, 3))
        else $error("toggle did not invert");
    a_np_write_only: assert property ($past(rstn, 2) && !$stable({np_word[15:12], np_word.code})
        |-> $past(mdc, 2)) else $error("np word changed outside a write");
    a_ta_drive_zero: assert property ($fell(mdio_oe_n) |-> mdio_out == 1'b0)
        else $error("turnaround not zero");
    a_read_drive_hold: assert property ($fell(mdio_oe_n) |=> !mdio_oe_n [*8])
        else $error("read drive too short");
    a_aux_guarded: assert property ($past(rstn, 2) && $changed(reserved_aux) |-> $past(cmd_override))
        else $error("reserved bits written without override");
endmodule : anx_regs_props

bind anx_regs anx_regs_props u_props (.clk, .rstn, .mdc, .mdio_out, .mdio_oe_n, .cmd_override, .an_status,
    .base_word_bit11, .base_word_sent, .np_word_sent, .np_word, .np_enable, .reserved_aux);

// ### dv/anx_sta_model.sv
`timescale 1ns/100ps
module anx_sta_model (
    input  wire logic clk,
    output logic      mdc,
    output wire logic mdio_in,
    input  wire logic mdio_out,
    input  wire logic mdio_oe_n
);
    logic drv;
    logic bit_o;
    // pulled-up shared line, either party may pull it low
    assign mdio_in = (drv ? bit_o : 1'b1) & (mdio_oe_n ? 1'b1 : mdio_out);
    // idle: clock stands low, line released
    initial begin
        mdc = 1'b0;
        drv = 1'b0;
        bit_o = 1'b1;
    end
    // one mdc period, 10 clk per half to stay above the slow-clock limit
    task automatic tick(output logic s);
        repeat (10) @(posedge clk);
        #1 mdc = 1'b1;
        s = mdio_in;
        repeat (10) @(posedge clk);
        #1 mdc = 1'b0;
    endtask : tick
    task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                         input logic [15:0] wd, output logic [15:0] rd);
        logic [63:0] f;
        logic        s;
        f = {32'hffffffff, 2'h1, op, pa, ra, 2'h2, wd};
        rd = 16'h0000;
        for (int i = 63; i >= 0; i--) begin
            drv = (op == 2'h1) || (i > 17);
            bit_o = f[i];
            tick(s);
            if (i < 16) rd = {rd[14:0], s};
        end
        drv = 1'b0;
    endtask : frame
endmodule : anx_sta_model

// ### dv/anx_regs_tb.sv
`timescale 1ns/100ps
module anx_regs_tb;
    localparam logic [4:0]   PA = 5'h0b;
    logic                    clk, rstn, cmd_override, base_word_bit11, base_word_sent, np_word_sent, b;
    wire                     mdc, mdio_in;
    logic                    mdio_out, mdio_oe_n, np_enable;
    logic [15:0]             rd;
    logic [10:0]             reserved_aux;
    anx_pkg::anx_an_status_t an_status;
    anx_pkg::anx_np_word_t   np_word;
    int                      error_cnt, comparisons;

    anx_regs uut (.clk, .rstn, .mdc, .mdio_in, .mdio_out, .mdio_oe_n, .phy_addr(PA), .cmd_override, .an_status,
        .base_word_bit11, .base_word_sent, .np_word_sent, .np_word, .np_enable, .reserved_aux);
    anx_sta_model sta (.clk, .mdc, .mdio_in, .mdio_out, .mdio_oe_n);

    // ------
    // helpers
    // ------
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic rd_reg(input logic [4:0] ra);
        sta.frame(2'h2, PA, ra, 16'h0000, rd);
    endtask : rd_reg
    task automatic wr_reg(input logic [4:0] ra, input logic [15:0] wd);
        logic [15:0] d;
        sta.frame(2'h1, PA, ra, wd, d);
        step(2);
    endtask : wr_reg
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : finish_test

    // ------
    // scenarios
    // ------
    task automatic t_defaults;
        rd_reg(5'h06); check("exp_reset", rd, 16'h0004);
        rd_reg(5'h07); check("nptx_reset", rd, 16'h2001);
        check("np_word_reset", np_word, 16'h2001);
        check("np_en_reset", np_enable, 1'b0);
        $display("test defaults done");
    endtask : t_defaults
    // fault and page pulse end before the read, so only the latch can report them
    task automatic t_status;
        an_status = 4'hd;
        step(2);
        an_status.page_stored = 1'b1;
        step(1);
        an_status.page_stored = 1'b0;
        an_status.pd_fault = 1'b0;
        step(4);
        rd_reg(5'h06); check("exp_latched", rd, 16'h001f);
        rd_reg(5'h06); check("exp_cleared", rd, 16'h000d);
        $display("test status done");
    endtask : t_status
    task automatic t_nptx;
        wr_reg(5'h07, 16'hffff); check("np_word_ones", np_word, 16'hb7ff);
        check("np_en_on", np_enable, 1'b1);
        rd_reg(5'h07); check("nptx_ones", rd, 16'hb7ff);
        an_status.lp_np_capable = 1'b0;
        step(2); check("np_en_off", np_enable, 1'b0);
        rd_reg(5'h06); check("exp_lp_np_off", rd, 16'h0005);
        wr_reg(5'h07, 16'h1555); check("np_word_mixed", np_word, 16'h1555);
        $display("test next page transmit done");
    endtask : t_nptx
    task automatic t_toggle;
        for (int i = 0; i < 2; i++) begin
            b = i[0];
            base_word_bit11 = b;
            step(1);
            base_word_sent = 1'b1;
            step(1);
            base_word_sent = 1'b0;
            step(3); check("toggle_first", np_word.toggle, !b);
            np_word_sent = 1'b1;
            step(1);
            np_word_sent = 1'b0;
            step(3); check("toggle_next", np_word.toggle, b);
            rd_reg(5'h07); check("nptx_toggle", rd[11], b);
        end
        wr_reg(5'h07, 16'h0000); rd_reg(5'h07); check("toggle_ro", rd, 16'h0800);
        $display("test toggle done");
    endtask : t_toggle
    task automatic t_override;
        wr_reg(5'h06, 16'hffe0); check("aux_locked", reserved_aux, 11'h000);
        cmd_override = 1'b1;
        wr_reg(5'h06, 16'hffe0); check("aux_open", reserved_aux, 11'h7ff);
        rd_reg(5'h06); check("exp_rsvd_zero", rd[15:5], 11'h000);
        wr_reg(5'h06, 16'h0000); check("aux_default", reserved_aux, 11'h000);
        cmd_override = 1'b0;
        $display("test override done");
    endtask : t_override
    task automatic t_refuse;
        sta.frame(2'h2, PA ^ 5'h01, 5'h06, 16'h0000, rd); check("other_addr", rd, 16'hffff);
        rd_reg(5'h08); check("unmapped", rd, 16'h0000);
        check("oe_idle", mdio_oe_n, 1'b1);
        $display("test refusals done");
    endtask : t_refuse

    // main sequence
    initial begin
        rstn = 1'b0;
        cmd_override = 1'b0;
        an_status = 4'h0;
        base_word_bit11 = 1'b0;
        base_word_sent = 1'b0;
        np_word_sent = 1'b0;
        error_cnt = 0;
        comparisons = 0;
        repeat (6) @(posedge clk);
        #1 rstn = 1'b1;
        step(3);
        t_defaults;
        t_status;
        t_nptx;
        t_toggle;
        t_override;
        t_refuse;
        finish_test;
    end
    // watchdog, about twice the expected run
    initial begin
        #400000;
        error_cnt++;
        finish_test;
    end
endmodule : anx_regs_tb
